// File: iexb_card.sv
/*
 * Card model for the far side of the expansion bus: one I/O word, one
 * memory word, a DMA requester and the ready, size and zero-wait answers.
 * Assumes the bench resolves strobes and data lines and hands them in.
 */
`timescale 1ns/10ps
module iexb_card (
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    input  wire logic        ior_w,
    input  wire logic        iow_w,
    input  wire logic        memr_w,
    input  wire logic        memw_w,
    input  wire logic        ref_w,
    input  wire logic [15:0] sd_w,
    input  wire logic [7:0]  dack_w,
    input  wire logic        wide16,    // Card decodes as sixteen-bit
    input  wire logic        fast,      // Card asks for zero wait
    input  wire logic        slow,      // Card stretches with ready
    input  wire logic [7:0]  dma_want,  // One-cycle request pulses
    output logic [15:0]      card_sd,
    output logic             card_oe,
    output logic             chrdy,
    output logic             cs16_n,
    output logic             zws_n,
    output logic [7:0]       drq
);
    logic [15:0] io_word;   // Last I/O write
    logic [15:0] mem_word;  // Last memory write
    logic [15:0] pick;      // Word for the running read
    logic [5:0]  hold;      // Cycles a strobe has been low
    logic [7:0]  dack_q;    // Acknowledge one cycle ago
    logic        act;       // Any strobe low

    ////////////////////////////////////////////////////////////////////////
    assign act    = !(ior_w & iow_w & memr_w & memw_w);
    // Open collector: pulled low or left to the pull-up
    assign cs16_n = !wide16;
    assign zws_n  = !fast;
    // Ready low for 40 cycles keeps a slow cycle stretched
    assign chrdy  = !(slow && act && hold < 6'h28);
    // No answer to a refresh read
    assign card_oe = !ior_w | (!memr_w & ref_w);
    assign pick    = !ior_w ? io_word : mem_word;
    // An eight-bit card leaves the upper byte to the pull-ups
    assign card_sd = wide16 ? pick : {8'hff, pick[7:0]};

    ////////////////////////////////////////////////////////////////////////
    // Capture write data while the strobe is low
    always_ff @(posedge core_clk) begin
        hold   <= act ? hold + ((hold == 6'h3f) ? 6'h00 : 6'h01) : 6'h00;
        dack_q <= dack_w;
        if (!iow_w) begin
            io_word <= wide16 ? sd_w : {8'h00, sd_w[7:0]};
        end
        if (!memw_w) begin
            mem_word <= wide16 ? sd_w : {8'h00, sd_w[7:0]};
        end
        // Request held until its acknowledge ends
        if (sys_rst) begin
            drq <= 8'h00;
        end else begin
            drq <= (drq & ~(dack_w & ~dack_q)) | dma_want;
        end
    end
endmodule : iexb_card

// File: iexb_host.sv
/*
 * Host end of the stacked expansion bus: bus clock and oscillator, reset
 * drive, address latching, memory and I/O strobes, 8/16-bit sizing with
 * wait states, DMA request ranking and acknowledge, refresh, bus-master
 * watchdog and interrupt ranking.
 * Assumes a processor-side request port on core_clk and a testbench that
 * resolves the two-way pins from the enables.
 */
// Overview of operation
// - Unlatched upper address; sixteen-bit data path
// - Card pulls ready low to extend cycle
// - Card pulls channel check low on parity
// - I/O read strobe: card drives data
// - I/O write strobe: card captures data
// - Card holds DMA request until done
// - Refresh marks refresh; master may drive it
// - Bus high enable marks valid upper byte
// - Master released within fifteen microseconds
// - Sixteen-bit select gives one wait state
// - Zero wait ends cycle; oscillator output runs
`timescale 1ns/10ps
module iexb_host
    import iexb_pkg::*;
#(
    parameter int MASTER_LIMIT = MASTER_MAX_CYC  // Cycles a card may hold the bus
) (
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    input  wire logic        power_fail,     // Power-up or low line voltage
    // Processor request port
    input  wire logic        req_valid,
    output logic             req_ready,
    input  wire logic [2:0]  req_cmd,
    input  wire logic [23:0] req_addr,
    input  wire logic [15:0] req_wdata,
    input  wire logic        req_wide,       // Processor asks for 16 bits
    output logic             rsp_valid,
    output logic [15:0]      rsp_rdata,
    // DMA controller side
    input  wire logic [7:0]  dma_tc_hit,     // Channel reaching terminal count
    output logic [7:0]       dma_grant,      // One-hot granted channel
    // Interrupt side
    output logic [3:0]       irq_top,        // Highest-priority pending request number
    output logic             irq_any,
    output logic             chk_err,        // Channel check seen
    output logic             master_over,    // Master held beyond limit
    // Bus pins
    output logic             bus_clk,
    output logic             bus_osc,
    output logic             rst_drive,
    output logic [19:0]      sa_out,
    output logic             sa_oe,
    output logic [23:17]     la_out,
    output logic             la_oe,
    input  wire logic [15:0] sd_in,
    output logic [15:0]      sd_out,
    output logic             sd_oe,
    output logic             ale,
    output logic             ior_n,
    output logic             iow_n,
    output logic             memr_n,
    output logic             memw_n,
    output logic             smemr_n,
    output logic             smemw_n,
    output logic             strobe_oe,      // Drives the four two-way strobes
    output logic             sbhe_n,
    output logic             refresh_out_n,
    output logic             refresh_oe,
    input  wire logic        refresh_in_n,
    output logic             aen,
    output logic             tc,
    output logic [7:0]       dack_n,
    input  wire logic [7:0]  drq,
    input  wire logic [15:0] irq,
    input  wire logic        chrdy,
    input  wire logic        chck_n,
    input  wire logic        master_n,
    input  wire logic        memcs16_n,
    input  wire logic        iocs16_n,
    input  wire logic        zws_n
);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [31:0] raw_pins;  // Gathered asynchronous pins
    logic [31:0] syn_pins;
    assign raw_pins = {drq, irq, chrdy, chck_n, master_n, memcs16_n,
                       iocs16_n, zws_n, refresh_in_n, power_fail};
    // Idle levels: strobe-type pins high, requests and power fail low
    iexb_sync #(.W(32), .INIT(32'h0000_00fe)) u_sync (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .pin_in   (raw_pins),
        .pin_sync (syn_pins)
    );
    wire [7:0]  s_drq   = syn_pins[31:24];
    wire [15:0] s_irq   = syn_pins[23:8];
    wire        s_rdy   = syn_pins[7];
    wire        s_chk_n = syn_pins[6];
    wire        s_mst_n = syn_pins[5];
    wire        s_m16_n = syn_pins[4];
    wire        s_i16_n = syn_pins[3];
    wire        s_zws_n = syn_pins[2];

    ////////////////////////////////////////////////////////////////////////
    // Bus clock and oscillator
    logic [3:0]  bclk_cnt;  // Divider count
    logic [31:0] osc_acc;   // Phase accumulator
    logic        bclk_fall; // Core cycle where the bus clock falls
    assign bclk_fall = (bclk_cnt == BCLK_HALF - 4'h1) && bus_clk;

    // Bus clock divided from the core clock, unrelated to the processor clock
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            bclk_cnt <= 4'h0;
            bus_clk  <= 1'b0;
        end else if (bclk_cnt == BCLK_HALF - 4'h1) begin
            bclk_cnt <= 4'h0;
            bus_clk  <= ~bus_clk;
        end else begin
            bclk_cnt <= bclk_cnt + 4'h1;
        end
    end

    // Oscillator is held at zero phase while sys_rst is high and runs after, also through a power-fail reset drive
    always_ff @(posedge core_clk) begin
        if (sys_rst) osc_acc <= 32'h0;
        else         osc_acc <= osc_acc + OSC_STEP;
    end
    assign bus_osc = osc_acc[31];

    // Reset drive follows board reset and power condition
    always_ff @(posedge core_clk) begin
        rst_drive <= sys_rst | syn_pins[0];
    end

    ////////////////////////////////////////////////////////////////////////
    // DMA and interrupt ranking
    // Fixed DMA rank: 0,1,2,3,5,6,7 (channel 4 is cascade, never granted)
    function automatic logic [7:0] dma_pick(input logic [7:0] r);
        logic [7:0] g;
        g = 8'h00;
        for (int i = 7; i >= 0; i--) begin
            if (i != 4 && r[i]) g = 8'h01 << i;
        end
        return g;
    endfunction : dma_pick

    // Interrupt rank: 9,10,11,12,13,15,3,4,5,6,7
    function automatic logic [3:0] irq_pick(input logic [15:0] r);
        logic [3:0] n;
        n = 4'h0;
        for (int i = 7; i >= 3; i--) if (r[i]) n = 4'(i);
        for (int i = 15; i >= 9; i--) if (i != 14 && r[i]) n = 4'(i);
        return n;
    endfunction : irq_pick

    wire [15:0] irq_live = s_irq & 16'hbef8;  // Inputs present on the bus
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            irq_top <= 4'h0;
            irq_any <= 1'b0;
            chk_err <= 1'b0;
        end else begin
            irq_top <= irq_pick(irq_live);
            irq_any <= |irq_live;
            chk_err <= ~s_chk_n;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus cycle sequencer
    iexb_state_t state, next_state;
    logic [2:0]  cmd;       // Held command
    logic        wide;      // Transfer is 16 bits
    logic [3:0]  wcnt;      // Remaining wait edges
    logic [7:0]  grant;     // Held DMA grant
    logic [31:0] mst_cnt;   // Cycles the master line has been low

    wire [7:0] pick     = dma_pick(s_drq);
    wire       low_meg  = (req_addr[23:20] == LOW_MEG_TOP);
    wire       is_mem   = (cmd == IEXB_CMD_MRD) || (cmd == IEXB_CMD_MWR);
    wire       in_str   = (state == IEXB_STROBE) || (state == IEXB_WAIT);
    wire       foreign  = ~s_mst_n;  // A card owns the bus
    wire       sel16    = is_mem ? ~s_m16_n : ~s_i16_n;

    always_comb begin
        next_state = state;
        case (state)
            IEXB_IDLE:   begin
                if (foreign)         next_state = IEXB_IDLE;
                // Start only on a bus clock edge, so a request that just
                // ended has left the synchroniser and is not granted twice
                else if (|pick)      next_state = bclk_fall ? IEXB_DMA : IEXB_IDLE;
                else if (req_valid)  next_state = IEXB_ALE;
            end
            IEXB_ALE:    if (bclk_fall) next_state = IEXB_STROBE;
            IEXB_STROBE: if (bclk_fall) next_state = IEXB_WAIT;
            IEXB_WAIT:   begin
                if (bclk_fall && (wcnt == 4'h0 || !s_zws_n) && s_rdy)
                    next_state = IEXB_DONE;
            end
            IEXB_DMA:    if (bclk_fall && (wcnt == 4'h0) && s_rdy)
                             next_state = IEXB_DONE;
            IEXB_DONE:   next_state = IEXB_IDLE;
            default:     next_state = IEXB_IDLE;
        endcase
    end
    assign req_ready = (state == IEXB_IDLE) && !foreign && !(|pick);

    // State register
    always_ff @(posedge core_clk) begin
        if (sys_rst) state <= IEXB_IDLE;
        else         state <= next_state;
    end

    // Latch the request and set the wait budget
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cmd   <= IEXB_CMD_MRD;
            wide  <= 1'b0;
            wcnt  <= WAIT_8BIT;
            grant <= 8'h00;
        end else if (state == IEXB_IDLE) begin
            cmd   <= req_cmd;
            wide  <= req_wide;
            wcnt  <= WAIT_8BIT;
            grant <= pick;
            if (|pick) wide <= |(pick & 8'he0);
        end else if (state == IEXB_STROBE && bclk_fall) begin
            if (!s_zws_n)   wcnt <= WAIT_ZERO;
            else if (sel16) wcnt <= WAIT_16BIT;
            wide <= wide & sel16;
        end else if (bclk_fall && wcnt != 4'h0 && s_rdy) begin
            wcnt <= wcnt - 4'h1;
        end
    end

    // Address, data and strobes
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            sa_out <= 20'h0;
            la_out <= 7'h0;
            sd_out <= 16'h0;
            smemr_n <= 1'b1;
            smemw_n <= 1'b1;
            rsp_rdata <= 16'h0;
        end else if (state == IEXB_IDLE && req_ready && req_valid) begin
            sa_out  <= req_addr[19:0];
            la_out  <= req_addr[23:17];
            sd_out  <= req_wdata;
            smemr_n <= !(req_cmd == IEXB_CMD_MRD && low_meg);
            smemw_n <= !(req_cmd == IEXB_CMD_MWR && low_meg);
        end else if (state == IEXB_WAIT && next_state == IEXB_DONE) begin
            rsp_rdata <= wide ? sd_in : {8'h00, sd_in[7:0]};
            smemr_n   <= 1'b1;  // System strobes end with the cycle
            smemw_n   <= 1'b1;
        end
    end

    // Refresh commands mark the cycle; no DMA pending is needed
    wire host_ref = (cmd == IEXB_CMD_REF) && (in_str || state == IEXB_ALE);
    assign ale           = (state == IEXB_ALE) || (state == IEXB_DMA);
    assign memr_n        = !(in_str && (cmd == IEXB_CMD_MRD || cmd == IEXB_CMD_REF));
    assign memw_n        = !(in_str && cmd == IEXB_CMD_MWR);
    assign ior_n         = !((in_str && cmd == IEXB_CMD_IORD)
                             || (state == IEXB_DMA && 1'b0));
    assign iow_n         = !(in_str && cmd == IEXB_CMD_IOWR);
    assign strobe_oe     = !foreign;
    assign sa_oe         = !foreign;
    assign la_oe         = !foreign;
    assign sd_oe         = in_str && (cmd == IEXB_CMD_MWR || cmd == IEXB_CMD_IOWR);
    assign sbhe_n        = !(wide && state != IEXB_IDLE);
    assign refresh_out_n = !host_ref;
    assign refresh_oe    = !foreign;  // A master may drive refresh itself
    assign aen           = (state == IEXB_DMA);
    assign dack_n        = ~((state == IEXB_DMA) ? grant : 8'h00);
    assign dma_grant     = (state == IEXB_DMA) ? grant : 8'h00;
    assign rsp_valid     = (state == IEXB_DONE) && (grant == 8'h00);

    // Terminal count pulse at the end of a DMA transfer that hit it
    always_ff @(posedge core_clk) begin
        if (sys_rst) tc <= 1'b0;
        else         tc <= (state == IEXB_DMA) && (next_state == IEXB_DONE)
                           && |(grant & dma_tc_hit);
    end

    // Watch the master line against its hold limit
    always_ff @(posedge core_clk) begin
        if (sys_rst || s_mst_n) begin
            mst_cnt     <= 32'h0;
            master_over <= 1'b0;
        end else begin
            if (mst_cnt != 32'(MASTER_LIMIT)) mst_cnt <= mst_cnt + 32'h1;
            else                              master_over <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    read_write_excl_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        !(!ior_n && !iow_n) && !(!memr_n && !memw_n))
        else $error("read and write strobes together");
    smem_low_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (!smemr_n && in_str) |-> (la_out[23:20] == LOW_MEG_TOP))
        else $error("system memory read above one megabyte");
    smemw_low_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (!smemw_n && in_str) |-> (la_out[23:20] == LOW_MEG_TOP))
        else $error("system memory write above one megabyte");
    dma_ale_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        aen |-> ale)
        else $error("latch enable low in DMA cycle");
    dack_one_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        $onehot0(~dack_n) && dack_n[4])
        else $error("more than one DMA acknowledge");
    dma_rank_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (state == IEXB_IDLE && s_drq[0] && !foreign) |=> (grant == 8'h01))
        else $error("channel 0 not granted first");
    tc_pulse_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        tc |=> !tc)
        else $error("terminal count longer than a pulse");
    rst_drive_a: assert property (@(posedge core_clk)
        sys_rst |=> rst_drive)
        else $error("reset drive low during reset");
endmodule : iexb_host

// File: iexb_host_tb_top.sv
/*
 * Self-checking bench for the expansion bus host with a card model.
 * Assumes the host asserts its own rules inside; the bench resolves pins.
 */
`timescale 1ns/10ps
module iexb_host_tb_top
    import iexb_pkg::*;
;
    typedef struct {
        iexb_cmd_t   c;  // Command
        logic [23:0] a;  // Address
        logic [15:0] w;  // Write data or expected read
        logic [3:0]  f;  // Wide, card16, zero wait, slow
        logic [15:0] m;  // Read mask, zero for writes
        logic [1:0]  e;  // Low-meg read, low-meg write expected
    } iexb_row_t;
    logic         core_clk, sys_rst, power_fail, req_valid, req_wide;
    logic [2:0]   req_cmd;
    logic [23:0]  req_addr;
    logic [15:0]  req_wdata, rsp_rdata, sd_out, sd_in, card_sd, irq, rd;
    logic         req_ready, rsp_valid, irq_any, chk_err, master_over;
    logic [7:0]   dma_tc_hit, dma_grant, dack_n, drq, dma_want, first_dack;
    logic [3:0]   irq_top;
    logic [19:0]  sa_out;
    logic [23:17] la_out;
    logic         bus_clk, bus_osc, rst_drive, sa_oe, la_oe, sd_oe, ale;
    logic         ior_n, iow_n, memr_n, memw_n, smemr_n, smemw_n, strobe_oe;
    logic         sbhe_n, refresh_out_n, refresh_oe, aen, tc, card_oe;
    logic         chrdy, chck_n, master_n, cs16_n, zws_n, wide16, fast, slow;
    logic         ior_w, iow_w, memr_w, memw_w, ref_w, any_w;
    logic         smr_seen, smw_seen, hb_seen, ref_seen, bad, tc_seen;
    int           mismatches, tests_run, cyc, slen, k;
    int           lens [10];
    iexb_row_t    rows [10] = '{
        '{IEXB_CMD_IOWR, 24'h000300, 16'ha55a, 4'hc, 16'h0000, 2'h0},
        '{IEXB_CMD_IORD, 24'h000300, 16'ha55a, 4'hc, 16'hffff, 2'h0},
        '{IEXB_CMD_IOWR, 24'h000310, 16'h1234, 4'h0, 16'h0000, 2'h0},
        '{IEXB_CMD_IORD, 24'h000310, 16'h0034, 4'h0, 16'h00ff, 2'h0},
        '{IEXB_CMD_MWR,  24'h0d0000, 16'hbeef, 4'hc, 16'h0000, 2'h1},
        '{IEXB_CMD_MRD,  24'h0d0000, 16'hbeef, 4'hc, 16'hffff, 2'h2},
        '{IEXB_CMD_MWR,  24'h100000, 16'hc3c3, 4'h0, 16'h0000, 2'h0},
        '{IEXB_CMD_MRD,  24'h100000, 16'h00c3, 4'h0, 16'h00ff, 2'h0},
        '{IEXB_CMD_MRD,  24'h0fffff, 16'h00c3, 4'h2, 16'h00ff, 2'h2},
        '{IEXB_CMD_IORD, 24'h000310, 16'h0034, 4'h1, 16'h00ff, 2'h0}};
    logic [15:0]  irq_pat [6] = '{16'h0088, 16'h8008, 16'h0600,
                                  16'h0080, 16'h2040, 16'h0000};
    logic [3:0]   irq_exp [6] = '{4'h3, 4'hf, 4'h9, 4'h7, 4'hd, 4'h0};

    ////////////////////////////////////////////////////////////////////////
    // Released lines sit at their pull-ups
    assign ior_w  = strobe_oe ? ior_n : 1'b1;
    assign iow_w  = strobe_oe ? iow_n : 1'b1;
    assign memr_w = strobe_oe ? memr_n : 1'b1;
    assign memw_w = strobe_oe ? memw_n : 1'b1;
    assign ref_w  = refresh_oe ? refresh_out_n : 1'b1;
    assign any_w  = !(ior_w & iow_w & memr_w & memw_w);
    assign sd_in  = sd_oe ? sd_out : (card_oe ? card_sd : 16'hffff);

    iexb_host #(.MASTER_LIMIT(20)) iexb_host_inst (
        .core_clk(core_clk), .sys_rst(sys_rst), .power_fail(power_fail),
        .req_valid(req_valid), .req_ready(req_ready), .req_cmd(req_cmd),
        .req_addr(req_addr), .req_wdata(req_wdata), .req_wide(req_wide),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .dma_tc_hit(dma_tc_hit),
        .dma_grant(dma_grant), .irq_top(irq_top), .irq_any(irq_any),
        .chk_err(chk_err), .master_over(master_over), .bus_clk(bus_clk),
        .bus_osc(bus_osc), .rst_drive(rst_drive), .sa_out(sa_out),
        .sa_oe(sa_oe), .la_out(la_out), .la_oe(la_oe), .sd_in(sd_in),
        .sd_out(sd_out), .sd_oe(sd_oe), .ale(ale), .ior_n(ior_n),
        .iow_n(iow_n), .memr_n(memr_n), .memw_n(memw_n), .smemr_n(smemr_n),
        .smemw_n(smemw_n), .strobe_oe(strobe_oe), .sbhe_n(sbhe_n),
        .refresh_out_n(refresh_out_n), .refresh_oe(refresh_oe),
        .refresh_in_n(ref_w), .aen(aen), .tc(tc), .dack_n(dack_n), .drq(drq),
        .irq(irq), .chrdy(chrdy), .chck_n(chck_n), .master_n(master_n),
        .memcs16_n(cs16_n), .iocs16_n(cs16_n), .zws_n(zws_n));

    iexb_card iexb_card_inst (
        .core_clk(core_clk), .sys_rst(sys_rst), .ior_w(ior_w), .iow_w(iow_w),
        .memr_w(memr_w), .memw_w(memw_w), .ref_w(ref_w), .sd_w(sd_in),
        .dack_w(dack_n), .wide16(wide16), .fast(fast), .slow(slow),
        .dma_want(dma_want), .card_sd(card_sd), .card_oe(card_oe),
        .chrdy(chrdy), .cs16_n(cs16_n), .zws_n(zws_n), .drq(drq));

    ////////////////////////////////////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    // Pin watcher: strobe length, seen flags, hang limit
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        slen <= slen + (any_w ? 1 : 0);
        if (!smemr_n) smr_seen <= 1'b1;
        if (!smemw_n) smw_seen <= 1'b1;
        if (!sbhe_n && any_w) hb_seen <= 1'b1;
        if (!ref_w && !memr_w) ref_seen <= 1'b1;
        if (tc) tc_seen <= 1'b1;
        if (dack_n !== 8'hff && first_dack == 8'h00) first_dack <= ~dack_n;
        // Strobe pairs, reserved acknowledge, DMA address ownership
        if (!sys_rst && ((!ior_w && !iow_w) || (!memr_w && !memw_w) ||
            !dack_n[4] || (dack_n !== 8'hff && !(aen && ale)))) bad <= 1'b1;
        if (cyc == 20000) begin
            mismatches++;
            results();
        end
    end

    task automatic chk_v(string nm, logic [15:0] exp, logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk_v

    task automatic tick(int n);
        repeat (n) @(posedge core_clk);
    endtask : tick

    // One processor request, held until taken, then wait for the answer
    task automatic bus_op(iexb_cmd_t c, logic [23:0] a, logic [15:0] w,
                          logic wd, output logic [15:0] rdat);
        {smr_seen, smw_seen, hb_seen, ref_seen} = 4'h0;
        req_cmd <= c;
        req_addr <= a;
        req_wdata <= w;
        req_wide <= wd;
        req_valid <= 1'b1;
        k = 0;
        do begin tick(1); k++; end while (req_ready !== 1'b1 && k < 400);
        req_valid <= 1'b0;
        do begin tick(1); k++; end while (rsp_valid !== 1'b1 && k < 800);
        rdat = rsp_rdata;
        chk_v("answer in time", 16'h1, k < 800);
    endtask : bus_op

    task automatic results;
        $display("Checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : results

    ////////////////////////////////////////////////////////////////////////
    initial begin
        {sys_rst, chck_n, master_n} = 3'h7;
        {power_fail, req_valid, req_wide, wide16, fast, slow} = 6'h00;
        {req_cmd, req_addr, req_wdata, irq} = '0;
        {dma_tc_hit, dma_want, first_dack} = 24'h0;
        {cyc, slen, mismatches, tests_run, bad, tc_seen} = '0;
        tick(20);
        chk_v("reset drive", 16'h1, rst_drive);
        chk_v("acks idle", 16'h00ff, dack_n);
        chk_v("aen idle", 16'h0, aen);
        sys_rst <= 1'b0;
        tick(5);
        chk_v("reset drive", 16'h0, rst_drive);
        $display("Test reset done");
        foreach (rows[i]) begin
            {wide16, fast, slow} <= rows[i].f[2:0];
            tick(1);
            lens[i] = slen;
            bus_op(rows[i].c, rows[i].a, rows[i].w, rows[i].f[3], rd);
            lens[i] = slen - lens[i];
            if (rows[i].m != 16'h0) chk_v("rdata", rows[i].w, rd & rows[i].m);
            chk_v("low read", rows[i].e[1], smr_seen);
            chk_v("low write", rows[i].e[0], smw_seen);
            chk_v("high byte", rows[i].f[3], hb_seen);
        end
        chk_v("wide shorter", 16'h1, lens[0] < lens[2]);
        chk_v("zero wait", 16'h1, lens[8] < lens[7]);
        chk_v("ready stretch", 16'h1, lens[9] > lens[3]);
        $display("Test bus cycles done");
        bus_op(IEXB_CMD_REF, 24'h0, 16'h0, 1'b0, rd);
        chk_v("refresh", 16'h1, ref_seen);
        foreach (irq_pat[i]) begin
            irq <= irq_pat[i];
            tick(6);
            chk_v("irq top", irq_exp[i], irq_top);
            chk_v("irq any", irq_pat[i] != 16'h0, irq_any);
        end
        $display("Test interrupts done");
        {first_dack, tc_seen} = 9'h0;
        dma_tc_hit <= 8'h08;
        dma_want <= 8'h29;
        tick(1);
        dma_want <= 8'h00;
        tick(5);
        chk_v("refused in dma", 16'h0, req_ready);
        k = 0;
        while ((drq !== 8'h00 || dack_n !== 8'hff) && k < 2000) begin tick(1); k++; end
        chk_v("dma drained", 16'h0, drq);
        chk_v("first grant", 16'h01, first_dack);
        chk_v("terminal count", 16'h1, tc_seen);
        $display("Test dma done");
        master_n <= 1'b0;
        tick(10);
        chk_v("master early", 16'h0, master_over);
        chk_v("refused master", 16'h0, req_ready);
        tick(20);
        chk_v("master late", 16'h1, master_over);
        master_n <= 1'b1;
        chck_n <= 1'b0;
        tick(5);
        chk_v("channel check", 16'h1, chk_err);
        chck_n <= 1'b1;
        power_fail <= 1'b1;
        tick(5);
        chk_v("low line", 16'h1, rst_drive);
        power_fail <= 1'b0;
        tick(5);
        chk_v("strobe pairs", 16'h0, bad);
        $display("Test pins done");
        results();
    end
endmodule : iexb_host_tb_top

// File: iexb_pkg.sv
/*
 * Package for the expansion bus host: command codes, bus timing counts,
 * the low-megabyte address top and state encodings.
 * Assumes a 40 MHz core clock; the divider, oscillator step and master limit derive from it.
 */
package iexb_pkg;

    // Core clock period in picoseconds
    localparam int CORE_PERIOD_PS = 25000;

    // Bus clock divider: half period in core cycles (bus clock = core / 6)
    localparam logic [3:0] BCLK_HALF = 4'h3;

    // Oscillator output, 14.31818 MHz, made from a 32-bit phase accumulator.
    // Step = f_osc / f_core * 2^32 = 0.3579545 * 2^32
    localparam logic [31:0] OSC_STEP = 32'h5ba2_e8b9;

    // Length of the master hold limit, in microseconds, and in core cycles
    localparam int MASTER_MAX_US  = 15;
    localparam int MASTER_MAX_CYC = (MASTER_MAX_US * 1000000) / CORE_PERIOD_PS;

    // Strobe timing in bus clock falling edges
    localparam logic [3:0] WAIT_8BIT  = 4'h4;  // Default 8-bit cycle length
    localparam logic [3:0] WAIT_16BIT = 4'h1;  // One wait state for 16-bit select
    localparam logic [3:0] WAIT_ZERO  = 4'h0;  // Zero wait state request

    // Top of the lowest one megabyte: address bits 23..20 zero
    localparam logic [3:0] LOW_MEG_TOP = 4'h0;

    // Command codes on the processor side
    typedef enum logic [2:0] {
        IEXB_CMD_MRD  = 3'h0,
        IEXB_CMD_MWR  = 3'h1,
        IEXB_CMD_IORD = 3'h2,
        IEXB_CMD_IOWR = 3'h3,
        IEXB_CMD_REF  = 3'h4
    } iexb_cmd_t;

    // Bus cycle states, one-hot
    typedef enum logic [5:0] {
        IEXB_IDLE   = 6'h01,
        IEXB_ALE    = 6'h02,
        IEXB_STROBE = 6'h04,
        IEXB_WAIT   = 6'h08,
        IEXB_DMA    = 6'h10,
        IEXB_DONE   = 6'h20
    } iexb_state_t;

endpackage : iexb_pkg

// File: iexb_sync.sv
/*
 * Two-flip-flop synchroniser for a vector of bus pins.
 * Assumes the pins are asynchronous to core_clk; the first stage is read by
 * the second stage only.
 */
`timescale 1ns/10ps
module iexb_sync #(
    parameter int W     = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input  wire logic         core_clk,
    input  wire logic         sys_rst,
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] pin_sync
);
    logic [W-1:0] meta;  // First stage, read only by the second

    // Two stages; reset to the idle level of the pins
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            meta     <= INIT;
            pin_sync <= INIT;
        end else begin
            meta     <= pin_in;
            pin_sync <= meta;
        end
    end
endmodule : iexb_sync
